// file: banked_mem_regs.svh
// Offsets, field positions, reset values and timing counts of the banked data memory
`ifndef BANKED_MEM_REGS_SVH
`define BANKED_MEM_REGS_SVH

`define OFS_INDIRECT_PORT_0   7'h00
`define OFS_INDIRECT_PORT_1   7'h01
`define OFS_PC_LOW            7'h02
`define OFS_STATUS            7'h03
`define OFS_PTR0_LOW          7'h04
`define OFS_PTR0_HIGH         7'h05
`define OFS_PTR1_LOW          7'h06
`define OFS_PTR1_HIGH         7'h07
`define OFS_BANK_SELECT       7'h08
`define OFS_ACCUMULATOR       7'h09
`define OFS_PC_UPPER_LATCH    7'h0A
`define OFS_INTERRUPT_CTRL    7'h0B
`define OFS_CORE_LAST         7'h0B
`define OFS_PERIPH_FIRST      7'h0C
`define OFS_PERIPH_LAST       7'h1F
`define OFS_GENERAL_FIRST     7'h20
`define OFS_GENERAL_LAST      7'h6F
`define OFS_COMMON_FIRST      7'h70

`define ST_WATCHDOG_EXPIRY    4
`define ST_SLEEP_ENTERED      3
`define ST_ZERO               2
`define ST_NIBBLE_CARRY       1
`define ST_CARRY              0
`define ST_WRITE_MASK         8'h07
`define ST_RESET              8'h18

`define LINEAR_BASE           16'h2000
`define PROGRAM_SELECT_BIT    15
`define PROGRAM_EXTRA_CYCLES  1

`endif

// file: banked_mem_pkg.sv
// Types shared by the banked data memory files
package banked_mem_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE    = 2'b00,
    ACC_PROGRAM = 2'b01,
    ACC_DONE    = 2'b11
  } access_state_e;

  typedef enum logic [2:0] {
    ALU_NONE   = 3'h0,
    ALU_ADD    = 3'h1,
    ALU_SUB    = 3'h2,
    ALU_LOGIC  = 3'h3,
    ALU_ROT_L  = 3'h4,
    ALU_ROT_R  = 3'h5
  } alu_op_e;
endpackage

// file: ram_block.sv
// Single-port RAM with registered read data
`timescale 1ns/100ps
module ram_block #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          core_clk_i,
  // Access
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule

// file: banked_data_memory_core_regs.sv
// Banked data memory: core registers, status flags, RAM regions, program reads
`timescale 1ns/100ps
`include "banked_mem_regs.svh"
module banked_data_memory_core_regs
  import banked_mem_pkg::*;
#(
  parameter int BANKS     = 32,
  parameter int PROG_AW   = 12,
  parameter int PROG_DW   = 14,
  parameter int PERIPH_W  = 8
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  // Direct or indirect file access from instruction execution
  input  wire logic                acc_req_i,
  input  wire logic                acc_write_i,
  input  wire logic                acc_indirect_i,
  input  wire logic                acc_ptr_sel_i,
  input  wire logic [6:0]          acc_offset_i,
  input  wire logic [7:0]          acc_wdata_i,
  input  wire logic                acc_to_accum_i,
  input  wire logic                acc_flag_write_i,
  output logic                     acc_done_o,
  output logic      [7:0]          acc_rdata_o,
  // Flag result of the executing instruction
  input  wire logic                alu_valid_i,
  input  wire alu_op_e             alu_op_i,
  input  wire logic [7:0]          alu_a_i,
  input  wire logic [7:0]          alu_b_i,
  output logic      [7:0]          alu_result_o,
  // Reset-status events
  input  wire logic                wdt_clear_i,
  input  wire logic                sleep_exec_i,
  input  wire logic                wdt_timeout_i,
  // Program memory read port
  output logic                     prog_rd_o,
  output logic      [PROG_AW-1:0]  prog_addr_o,
  input  wire logic [PROG_DW-1:0]  prog_rdata_i,
  // Peripheral register region
  output logic                     periph_we_o,
  output logic                     periph_re_o,
  output logic      [11:0]         periph_addr_o,
  output logic      [7:0]          periph_wdata_o,
  input  wire logic [7:0]          periph_rdata_i,
  // Core register views
  output logic      [7:0]          status_o,
  output logic      [7:0]          bank_select_o,
  output logic      [7:0]          accumulator_o
);
  localparam int BW = $clog2(BANKS);

  ////////////////////////////////////////////////////////////////////////////
  // Core registers
  logic [7:0]  status_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [7:0]  pcl_q;
  logic [7:0]  bsr_q;
  logic [7:0]  working_accumulator_q;
  logic [7:0]  program_counter_upper_latch_q;
  logic [7:0]  interrupt_control_q;
  access_state_e state_q;

  // Effective address
  logic [15:0] ptr_sel;
  logic        prog_sel;
  logic [11:0] eff_addr;
  logic        linear;
  logic [6:0]  ofs;
  logic [11:0] lin_idx;

  always_comb begin
    ptr_sel  = acc_ptr_sel_i ? ptr1_q : ptr0_q;
    prog_sel = acc_indirect_i && ptr_sel[`PROGRAM_SELECT_BIT];
    linear   = acc_indirect_i && !prog_sel && (ptr_sel[15:13] == 3'b001);
    if (acc_indirect_i) begin
      eff_addr = ptr_sel[11:0];
    end else begin
      eff_addr = {bsr_q[4:0], acc_offset_i};
    end
    ofs     = eff_addr[6:0];
    lin_idx = ptr_sel[11:0];
  end

  // Linear general RAM mapped to banked storage
  logic [BW-1:0] lin_bank;
  logic [6:0]    lin_ofs;
  logic          lin_ok;
  always_comb begin
    lin_bank = BW'(lin_idx / 12'd80);
    lin_ofs  = 7'(lin_idx % 12'd80) + `OFS_GENERAL_FIRST;
    lin_ok   = (lin_idx < 12'(BANKS * 80));
  end

  // Region decode
  logic is_core;
  logic is_periph;
  logic is_gen;
  logic is_common;
  always_comb begin
    is_core   = !linear && !prog_sel && (ofs <= `OFS_CORE_LAST);
    is_periph = !linear && !prog_sel && (ofs >= `OFS_PERIPH_FIRST)
                && (ofs <= `OFS_PERIPH_LAST);
    is_gen    = (linear && lin_ok) || (!linear && !prog_sel
                && (ofs >= `OFS_GENERAL_FIRST) && (ofs <= `OFS_GENERAL_LAST));
    is_common = !linear && !prog_sel && (ofs >= `OFS_COMMON_FIRST);
  end

  ////////////////////////////////////////////////////////////////////////////
  // RAM: 80 bytes per bank plus 16 common bytes
  logic [BW+6:0] ram_addr;
  logic          ram_we;
  logic [7:0]    ram_rdata;
  always_comb begin
    if (linear) begin
      ram_addr = {lin_bank, lin_ofs - `OFS_GENERAL_FIRST};
    end else if (is_common) begin
      ram_addr = {{BW{1'b1}}, 7'h50 + (ofs - `OFS_COMMON_FIRST)};
    end else begin
      ram_addr = {eff_addr[BW+6:7], ofs - `OFS_GENERAL_FIRST};
    end
    ram_we = acc_req_i && acc_write_i && (is_gen || is_common) && state_q == ACC_IDLE;
  end

  ram_block #(
    .AW(BW + 7),
    .DW(8)
  ) u_ram (
    .core_clk_i(core_clk_i),
    .we_i      (ram_we),
    .addr_i    (ram_addr),
    .wdata_i   (acc_wdata_i),
    .rdata_o   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing
  logic       start;
  logic       rd_core_q;
  logic       rd_ram_q;
  logic       rd_per_q;
  logic       prog_rd_q;
  logic [7:0] core_rd_q;
  assign start = acc_req_i && state_q == ACC_IDLE;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ACC_IDLE;
    end else begin
      case (state_q)
        ACC_IDLE: begin
          if (acc_req_i && prog_sel && !acc_write_i) begin
            state_q <= ACC_PROGRAM;
          end else if (acc_req_i) begin
            state_q <= ACC_DONE;
          end
        end
        ACC_PROGRAM: state_q <= ACC_DONE;
        ACC_DONE:    state_q <= ACC_IDLE;
        default:     state_q <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_rd_o   <= 1'b0;
      prog_addr_o <= '0;
    end else begin
      prog_rd_o <= start && prog_sel && !acc_write_i;
      if (start && prog_sel) begin
        prog_addr_o <= ptr_sel[PROG_AW-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      periph_we_o    <= 1'b0;
      periph_re_o    <= 1'b0;
      periph_addr_o  <= '0;
      periph_wdata_o <= '0;
    end else begin
      periph_we_o <= start && is_periph && acc_write_i;
      periph_re_o <= start && is_periph && !acc_write_i;
      if (start && is_periph) begin
        periph_addr_o  <= eff_addr;
        periph_wdata_o <= acc_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_core_q <= 1'b0;
      rd_ram_q  <= 1'b0;
      rd_per_q  <= 1'b0;
      core_rd_q <= '0;
    end else if (start) begin
      rd_core_q <= is_core;
      rd_ram_q  <= is_gen || is_common;
      rd_per_q  <= is_periph;
      case (ofs[3:0])
        4'h2:    core_rd_q <= pcl_q;
        4'h3:    core_rd_q <= status_q;
        4'h4:    core_rd_q <= ptr0_q[7:0];
        4'h5:    core_rd_q <= ptr0_q[15:8];
        4'h6:    core_rd_q <= ptr1_q[7:0];
        4'h7:    core_rd_q <= ptr1_q[15:8];
        4'h8:    core_rd_q <= bsr_q;
        4'h9:    core_rd_q <= working_accumulator_q;
        4'hA:    core_rd_q <= program_counter_upper_latch_q;
        4'hB:    core_rd_q <= interrupt_control_q;
        default: core_rd_q <= 8'h00;
      endcase
    end
  end

  // Read return; unmatched sources give zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_done_o  <= 1'b0;
      acc_rdata_o <= '0;
    end else begin
      acc_done_o <= (state_q == ACC_DONE);
      if (state_q == ACC_DONE) begin
        if (rd_ram_q) begin
          acc_rdata_o <= ram_rdata;
        end else if (rd_per_q) begin
          acc_rdata_o <= periph_rdata_i;
        end else if (rd_core_q) begin
          acc_rdata_o <= core_rd_q;
        end else if (prog_rd_q) begin
          acc_rdata_o <= prog_rdata_i[7:0];
        end else begin
          acc_rdata_o <= 8'h00;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prog_rd_q <= 1'b0;
    end else if (start) begin
      prog_rd_q <= prog_sel && !acc_write_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag arithmetic
  logic [7:0] b_eff;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] res;
  logic       c_new;
  logic       dc_new;
  always_comb begin
    // Inverted operand plus a carry-in of one keeps the carry of the +1 visible
    b_eff    = (alu_op_i == ALU_SUB) ? ~alu_b_i : alu_b_i;
    low_sum  = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]}
               + {4'h0, (alu_op_i == ALU_SUB)};
    full_sum = {1'b0, alu_a_i} + {1'b0, b_eff}
               + {8'h00, (alu_op_i == ALU_SUB)};
    dc_new   = low_sum[4];
    c_new    = full_sum[8];
    case (alu_op_i)
      ALU_ADD, ALU_SUB: res = full_sum[7:0];
      ALU_ROT_L:        res = {alu_a_i[6:0], status_q[`ST_CARRY]};
      ALU_ROT_R:        res = {status_q[`ST_CARRY], alu_a_i[7:1]};
      default:          res = alu_b_i;
    endcase
  end

  logic core_wr;
  assign core_wr = start && acc_write_i && is_core;

  // Status register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= `ST_RESET;
    end else begin
      if (core_wr && ofs == `OFS_STATUS && !acc_flag_write_i) begin
        status_q[2:0] <= acc_wdata_i[2:0];
      end
      if (alu_valid_i && alu_op_i != ALU_NONE) begin
        if (alu_op_i != ALU_ROT_L && alu_op_i != ALU_ROT_R) begin
          status_q[`ST_ZERO] <= (res == 8'h00);
        end
        if (alu_op_i == ALU_ADD || alu_op_i == ALU_SUB) begin
          status_q[`ST_NIBBLE_CARRY] <= dc_new;
          status_q[`ST_CARRY]        <= c_new;
        end else if (alu_op_i == ALU_ROT_L) begin
          status_q[`ST_CARRY] <= alu_a_i[7];
        end else if (alu_op_i == ALU_ROT_R) begin
          status_q[`ST_CARRY] <= alu_a_i[0];
        end
      end
      if (wdt_clear_i || sleep_exec_i) begin
        status_q[`ST_WATCHDOG_EXPIRY] <= 1'b1;
      end else if (wdt_timeout_i) begin
        status_q[`ST_WATCHDOG_EXPIRY] <= 1'b0;
      end
      if (wdt_clear_i) begin
        status_q[`ST_SLEEP_ENTERED] <= 1'b1;
      end else if (sleep_exec_i) begin
        status_q[`ST_SLEEP_ENTERED] <= 1'b0;
      end
    end
  end

  // Other core registers; indirect port writes to program memory are dropped
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr0_q   <= '0;
      ptr1_q   <= '0;
      pcl_q    <= '0;
      bsr_q    <= '0;
      working_accumulator_q   <= '0;
      program_counter_upper_latch_q <= '0;
      interrupt_control_q <= '0;
    end else begin
      if (core_wr) begin
        case (ofs[3:0])
          4'h2: pcl_q        <= acc_wdata_i;
          4'h4: ptr0_q[7:0]  <= acc_wdata_i;
          4'h5: ptr0_q[15:8] <= acc_wdata_i;
          4'h6: ptr1_q[7:0]  <= acc_wdata_i;
          4'h7: ptr1_q[15:8] <= acc_wdata_i;
          4'h8: bsr_q        <= {3'b000, acc_wdata_i[4:0]};
          4'h9: working_accumulator_q       <= acc_wdata_i;
          4'hA: program_counter_upper_latch_q     <= acc_wdata_i;
          4'hB: interrupt_control_q     <= acc_wdata_i;
          default: ;
        endcase
      end
      if (state_q == ACC_DONE && acc_to_accum_i && prog_rd_q) begin
        working_accumulator_q <= prog_rdata_i[7:0];
      end
    end
  end
  // prog_sel excludes is_gen/is_core/is_periph, so no store happens

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      alu_result_o  <= '0;
      status_o      <= `ST_RESET;
      bank_select_o <= '0;
      accumulator_o <= '0;
    end else begin
      alu_result_o  <= res;
      status_o      <= status_q;
      bank_select_o <= bsr_q;
      accumulator_o <= working_accumulator_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_PROG_EXTRA: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (start && prog_sel && !acc_write_i) |=> state_q == ACC_PROGRAM ##1 state_q == ACC_DONE
    ##1 acc_done_o) else $error("program read lacks extra cycle");
  AST_DATA_TIMING: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (start && !prog_sel) |=> state_q == ACC_DONE ##1 acc_done_o)
    else $error("data access timing wrong");
  AST_PROG_SELECT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (start && prog_sel && !acc_write_i) |=> prog_rd_o) else $error("no program fetch");
  AST_NO_PROG_WRITE: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (start && prog_sel && acc_write_i) |-> !ram_we ##1 (!periph_we_o && !prog_rd_o))
    else $error("program write stored");
  AST_BANK: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (core_wr && ofs == `OFS_BANK_SELECT) |=> bsr_q[4:0] == $past(acc_wdata_i[4:0]))
    else $error("bank select not taken");
  AST_UNMAPPED_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (start && !acc_write_i && !is_core && !is_gen && !is_common && !is_periph && !prog_sel)
    |=> ##1 acc_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_SLEEP_FLAG: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (sleep_exec_i && !wdt_clear_i) |=> !status_q[`ST_SLEEP_ENTERED]
    && status_q[`ST_WATCHDOG_EXPIRY]) else $error("sleep flags wrong");
  AST_TIMEOUT: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (wdt_timeout_i && !wdt_clear_i && !sleep_exec_i) |=> !status_q[`ST_WATCHDOG_EXPIRY])
    else $error("timeout flag not cleared");
  AST_CARRY_ADD: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (alu_valid_i && alu_op_i == ALU_ADD) |=> status_q[`ST_CARRY]
    == ($past({1'b0, alu_a_i}) + $past({1'b0, alu_b_i}) > 9'h0FF)) else $error("carry wrong");
  AST_ZERO: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (alu_valid_i && alu_op_i == ALU_LOGIC) |=> status_q[`ST_ZERO] == ($past(alu_b_i) == 8'h00))
    else $error("zero flag wrong");
  COV_PROG: cover property (@(posedge core_clk_i) start && prog_sel && !acc_write_i);
  COV_LINEAR: cover property (@(posedge core_clk_i) start && linear);
  COV_COMMON: cover property (@(posedge core_clk_i) start && is_common && acc_write_i);
endmodule

// file: banked_data_memory_core_regs_bench.sv
// Self-checking bench of the banked data memory against an integer reference model
`timescale 1ns/100ps
`include "banked_mem_regs.svh"
module banked_data_memory_core_regs_bench;
  import banked_mem_pkg::*;

  localparam int LIN [5] = '{0, 79, 80, 1111, 2559};

  logic        core_clk_i = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        req = 1'b0, wr = 1'b0, ind = 1'b0, psel = 1'b0, toa = 1'b0, flw = 1'b0;
  logic [6:0]  ofs = 7'h00;
  logic [7:0]  wd = 8'h00, aa = 8'h00, ab = 8'h00;
  logic        av = 1'b0, wclr = 1'b0, slp = 1'b0, wto = 1'b0;
  alu_op_e     aop = ALU_NONE;
  logic        done, prd, pwe, pre;
  logic [7:0]  rdat, ares, pwd, st, bsel, accv;
  logic [7:0]  prdat = 8'h00;
  logic [11:0] paddr, padr, last_pa;
  logic [13:0] pdat = 14'h0000;
  logic [7:0]  mdl [int];
  logic [7:0]  mst, rd_s;
  logic [19:0] pw_q [$];
  int          n_errors = 0, num_checks = 0, n_prd = 0, lat_s, dlat;

  banked_data_memory_core_regs u_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .acc_req_i(req), .acc_write_i(wr),
    .acc_indirect_i(ind), .acc_ptr_sel_i(psel), .acc_offset_i(ofs), .acc_wdata_i(wd),
    .acc_to_accum_i(toa), .acc_flag_write_i(flw), .acc_done_o(done), .acc_rdata_o(rdat),
    .alu_valid_i(av), .alu_op_i(aop), .alu_a_i(aa), .alu_b_i(ab), .alu_result_o(ares),
    .wdt_clear_i(wclr), .sleep_exec_i(slp), .wdt_timeout_i(wto), .prog_rd_o(prd),
    .prog_addr_o(paddr), .prog_rdata_i(pdat), .periph_we_o(pwe), .periph_re_o(pre),
    .periph_addr_o(padr), .periph_wdata_o(pwd), .periph_rdata_i(prdat), .status_o(st),
    .bank_select_o(bsel), .accumulator_o(accv));

  always #5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Program memory and peripheral side; data lines toggle when not answering
  function automatic logic [13:0] rom(logic [11:0] a);
    return {a[1:0], a} ^ 14'h2A5C;
  endfunction

  function automatic logic [7:0] pval(logic [11:0] a);
    return a[7:0] ^ {a[11:8], 4'hA};
  endfunction

  always @(posedge core_clk_i) begin
    pdat <= #1 prd ? rom(paddr) : ~pdat;
    if (prd) begin
      n_prd <= n_prd + 1;
      last_pa <= paddr;
    end
    if (pwe) pw_q.push_back({padr, pwd});
  end

  // Peripheral answers in the cycle in which its read strobe stands
  always @(posedge core_clk_i) begin
    #1;
    prdat = pre ? pval(padr) : ~prdat;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference model
  function automatic int key(logic [6:0] o);
    if (o < `OFS_GENERAL_FIRST || o >= `OFS_COMMON_FIRST) return int'(o);
    return int'(mdl[`OFS_BANK_SELECT][4:0]) * 128 + int'(o);
  endfunction

  function automatic logic [7:0] exp_rd(logic [6:0] o);
    logic [4:0] b;
    b = mdl[`OFS_BANK_SELECT][4:0];
    if (o <= `OFS_INDIRECT_PORT_1) return 8'h00;
    if (o == `OFS_STATUS) return mst;
    if (o == `OFS_BANK_SELECT) return {3'b000, b};
    if (o >= `OFS_PERIPH_FIRST && o <= `OFS_PERIPH_LAST) return pval({b, o});
    return mdl[key(o)];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task automatic check(string nm, logic [19:0] exp, logic [19:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic acc(logic w, i, p, logic [6:0] o, logic [7:0] d, logic ta, fw);
    @(posedge core_clk_i);
    #1;
    {req, wr, ind, psel, toa, flw, ofs, wd} = {1'b1, w, i, p, ta, fw, o, d};
    lat_s = 0;
    do begin
      @(posedge core_clk_i);
      #1;
      lat_s++;
      if (lat_s > 20) begin
        n_errors++;
        final_report();
      end
    end while (done !== 1'b1);
    rd_s = rdat;
    req = 1'b0;
    if (w && !i) begin
      if (o == `OFS_STATUS) mst = {3'b000, mst[4:3], fw ? mst[2:0] : d[2:0]};
      else mdl[key(o)] = d;
    end
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic wrd(logic [6:0] o, logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, o, d, 1'b0, 1'b0);
  endtask

  task automatic rd_chk(string nm, logic [6:0] o);
    acc(1'b0, 1'b0, 1'b0, o, 8'($urandom), 1'b0, 1'b0);
    check(nm, exp_rd(o), rd_s);
  endtask

  task automatic alu(alu_op_e op, logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] t;
    logic [7:0] bb, r, m;
    r = b;
    m = 8'h19;
    if (op == ALU_ROT_L || op == ALU_ROT_R) mst[0] = (op == ALU_ROT_L) ? a[7] : a[0];
    else if (op == ALU_LOGIC) begin
      m = 8'h1C;
      mst[2] = (b == 8'h00);
    end else begin
      bb = (op == ALU_SUB) ? ~b : b;
      s = 9'(a) + 9'(bb) + 9'(op == ALU_SUB);
      t = 5'(a[3:0]) + 5'(bb[3:0]) + 5'(op == ALU_SUB);
      r = s[7:0];
      m = 8'h1F;
      mst = {3'b000, mst[4:3], r == 8'h00, t[4], s[8]};
    end
    @(posedge core_clk_i);
    #1;
    av = 1'b1;
    aop = op;
    {aa, ab} = {a, b};
    @(posedge core_clk_i);
    #1;
    av = 1'b0;
    if (op != ALU_ROT_L && op != ALU_ROT_R) check("alu result", r, ares);
    repeat (2) @(posedge core_clk_i);
    check("status flags", mst & m, st & m);
  endtask

  task automatic evt(int k);
    @(posedge core_clk_i);
    #1;
    {wclr, slp, wto} = 3'b100 >> k;
    @(posedge core_clk_i);
    #1;
    {wclr, slp, wto} = 3'b000;
    mst[4:3] = (k == 0) ? 2'b11 : (k == 1) ? 2'b10 : {1'b0, mst[3]};
    repeat (2) @(posedge core_clk_i);
    check("reset status bits", mst, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    logic [14:0] pa;
    logic [13:0] pw;
    logic [7:0]  v;
    int          n;
    void'($urandom(84661));
    mdl[`OFS_BANK_SELECT] = 8'h00;
    mst = `ST_RESET;
    repeat (12) @(posedge core_clk_i);
    #1;
    resetn_i = 1'b1;
    check("status after reset", `ST_RESET, st);
    rd_chk("unimplemented core", `OFS_INDIRECT_PORT_0);
    for (int b = 0; b < 32; b += 7) begin
      wrd(`OFS_BANK_SELECT, 8'(b) | 8'hE0);
      check("bank select view", 8'(b), bsel);
      wrd(7'(`OFS_GENERAL_FIRST + b), 8'($urandom));
      wrd(`OFS_GENERAL_LAST, 8'($urandom));
      wrd(7'(`OFS_COMMON_FIRST + b % 16), 8'($urandom));
      v = 8'($urandom);
      wrd(7'(`OFS_PERIPH_FIRST + b % 20), v);
      check("peripheral write", {5'(b), 7'(`OFS_PERIPH_FIRST + b % 20), v}, pw_q.pop_front());
      wrd(`OFS_ACCUMULATOR, 8'($urandom));
      check("accumulator view", mdl[`OFS_ACCUMULATOR], accv);
    end
    for (int b = 28; b >= 0; b -= 7) begin
      wrd(`OFS_BANK_SELECT, 8'(b));
      rd_chk("bank select", `OFS_BANK_SELECT);
      rd_chk("general ram", 7'(`OFS_GENERAL_FIRST + b));
      rd_chk("general ram top", `OFS_GENERAL_LAST);
      rd_chk("common ram", 7'(`OFS_COMMON_FIRST + (b + 7) % 35 % 16));
      rd_chk("accumulator", `OFS_ACCUMULATOR);
      rd_chk("peripheral read", 7'(`OFS_PERIPH_FIRST + b % 20));
    end
    for (int k = 0; k < 40; k++) begin
      v = 8'($urandom);
      n = k % 5;
      alu(alu_op_e'(n + 1), v, (n > 2) ? v : 8'($urandom));
    end
    alu(ALU_SUB, 8'h3C, 8'h3C);
    alu(ALU_SUB, 8'h10, 8'h01);
    alu(ALU_ADD, 8'hFF, 8'h01);
    wrd(`OFS_STATUS, 8'hFF);
    rd_chk("status write", `OFS_STATUS);
    acc(1'b1, 1'b0, 1'b0, `OFS_STATUS, 8'h00, 1'b0, 1'b1);
    rd_chk("status guarded write", `OFS_STATUS);
    for (int k = 1; k < 4; k++) evt(k % 3);
    foreach (LIN[j]) begin
      n = LIN[j];
      v = 8'($urandom);
      wrd(`OFS_PTR1_LOW, 8'(n));
      wrd(`OFS_PTR1_HIGH, 8'(n >> 8) | 8'h20);
      acc(1'b1, 1'b1, 1'b1, `OFS_INDIRECT_PORT_1, v, 1'b0, 1'b0);
      mdl[(n / 80) * 128 + 32 + n % 80] = v;
      acc(1'b0, 1'b1, 1'b1, `OFS_INDIRECT_PORT_1, 8'h00, 1'b0, 1'b0);
      dlat = lat_s;
      check("linear read", v, rd_s);
      wrd(`OFS_BANK_SELECT, 8'(n / 80));
      rd_chk("linear to banked", 7'(`OFS_GENERAL_FIRST + n % 80));
    end
    wrd(`OFS_PTR1_HIGH, 8'h2A);
    acc(1'b0, 1'b1, 1'b1, `OFS_INDIRECT_PORT_1, 8'h00, 1'b0, 1'b0);
    check("linear beyond ram", 8'h00, rd_s);
    for (int k = 0; k < 4; k++) begin
      pa = 15'($urandom);
      wrd(`OFS_PTR0_LOW, pa[7:0]);
      wrd(`OFS_PTR0_HIGH, {1'b1, pa[14:8]});
      n = n_prd;
      acc(1'b0, 1'b1, 1'b0, `OFS_INDIRECT_PORT_0, 8'h00, 1'b1, 1'b0);
      pw = rom(pa[11:0]);
      mdl[`OFS_ACCUMULATOR] = pw[7:0];
      check("program fetches", n + 1, n_prd);
      check("program byte", pw[7:0], rd_s);
      check("program address", pa[11:0], last_pa);
      check("program latency", dlat + 1, lat_s);
      check("accumulator view", pw[7:0], accv);
    end
    n = n_prd;
    acc(1'b1, 1'b1, 1'b0, `OFS_INDIRECT_PORT_0, 8'hA5, 1'b0, 1'b0);
    check("program write fetches", n, n_prd);
    check("peripheral writes", 0, pw_q.size());
    rd_chk("accumulator kept", `OFS_ACCUMULATOR);
    final_report();
  end
endmodule
